// ---- hdl/pdmux_defs.vh ----
// Constants for the port D/E alternate-function override block.
// Assumes a 32-bit Avalon-MM slave with byte addresses and word registers.
`ifndef PDMUX_DEFS_VH
`define PDMUX_DEFS_VH

// Register byte offsets
`define PDMUX_OFS_DDATA   5'h00
`define PDMUX_OFS_DDIR    5'h04
`define PDMUX_OFS_DPIN    5'h08
`define PDMUX_OFS_EDATA   5'h0c
`define PDMUX_OFS_EDIR    5'h10
`define PDMUX_OFS_EPIN    5'h14
`define PDMUX_OFS_CTRL    5'h18

// Control register field positions
`define PDMUX_CTL_PUD     0
`define PDMUX_CTL_EXTMEM  1
`define PDMUX_CTL_T2ASYNC 2
`define PDMUX_CTL_TX0EN   3
`define PDMUX_CTL_RX0EN   4
`define PDMUX_CTL_S0SYNC  5
`define PDMUX_CTL_S1SYNC  6
`define PDMUX_CTL_IRQ0EN  7
`define PDMUX_CTL_IRQ1EN  8
`define PDMUX_CTL_IRQ2EN  9
`define PDMUX_CTL_T1AEN   10
`define PDMUX_CTL_T3AEN   11
`define PDMUX_CTL_T1BEN   12
`define PDMUX_CTL_WIDTH   13

// Reset values
`define PDMUX_RST_CTRL    13'h0000
`define PDMUX_RST_PORTD   8'h00
`define PDMUX_RST_PORTE   3'h0

`endif

// ---- hdl/pdmux_sync.v ----
// Two-flop synchroniser for a group of pad inputs.
// Assumes the inputs are asynchronous to clock; output is clock-domain.
module pdmux_sync #(
	parameter WIDTH = 8
) (
	input  wire             clock,
	input  wire             srst,
	input  wire [WIDTH-1:0] asyncIn,
	output wire [WIDTH-1:0] syncOut
);

	reg [WIDTH-1:0] meta_q;
	reg [WIDTH-1:0] sync_q;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : gBit
			// First stage feeds only the second stage
			always @(posedge clock) begin
				if (srst) begin
					meta_q[i] <= 1'b0;
					sync_q[i] <= 1'b0;
				end else begin
					meta_q[i] <= asyncIn[i];
					sync_q[i] <= meta_q[i];
				end
			end
		end
	endgenerate

	assign syncOut = sync_q;

endmodule

// ---- hdl/pdmux_top.v ----
// Alternate-function override for port D (8 pins) and port E (3 pins).
// Assumes pad cells outside resolve the pin from out, active-low
// output enable and pull-up; peripheral signals share clock.
//
// Local design decisions: the address map and the Avalon-MM register port.
`include "pdmux_defs.vh"
module pdmux_top (
	input  wire        clock,
	input  wire        srst,
	input  wire [4:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	output reg  [31:0] avs_readdata,
	output reg         avs_waitrequest,
	input  wire [7:0]  padDIn,
	output reg  [7:0]  padDOut,
	output reg  [7:0]  padDOeN,
	output reg  [7:0]  padDPullUp,
	output reg  [7:0]  padDInEn,
	input  wire [2:0]  padEIn,
	output reg  [2:0]  padEOut,
	output reg  [2:0]  padEOeN,
	output reg  [2:0]  padEPullUp,
	output reg  [2:0]  padEInEn,
	input  wire        serial0TxLine,
	input  wire        serial0ExtClockOut,
	input  wire        serial1ExtClockOut,
	input  wire        memReadStrobe,
	input  wire        memWriteStrobe,
	input  wire        memAddrLatch,
	input  wire        timer1CompareAOut,
	input  wire        timer3CompareAOut,
	input  wire        timer1CompareBOut,
	output reg         extIrqZero,
	output reg         extIrqOne,
	output reg         extIrqTwo,
	output reg         captureInTimer1,
	output reg         captureInTimer3,
	output reg         serial0RxLine,
	output reg         serial0ExtClockIn,
	output reg         serial1ExtClockIn
);

	// Pick the override value when its enable is set
	function pick;
		input en;
		input ovr;
		input sw;
		begin
			pick = en ? ovr : sw;
		end
	endfunction

	// Register word decode, shared by read and write paths
	function hit;
		input [4:0] addr;
		input [4:0] ofs;
		begin
			hit = (addr[4:2] == ofs[4:2]);
		end
	endfunction

	reg  [7:0]                  dataD_q;
	reg  [7:0]                  dirD_q;
	reg  [2:0]                  dataE_q;
	reg  [2:0]                  dirE_q;
	reg  [`PDMUX_CTL_WIDTH-1:0] ctrl_q;
	wire [7:0]                  syncD;
	wire [2:0]                  syncE;
	reg  [7:0]                  inD;
	reg  [2:0]                  inE;
	reg  [7:0]                  outD_d;
	reg  [7:0]                  oeND_d;
	reg  [7:0]                  puD_d;
	reg  [7:0]                  ieD_d;
	reg  [2:0]                  outE_d;
	reg  [2:0]                  oeNE_d;
	reg  [2:0]                  puE_d;
	reg  [2:0]                  ieE_d;
	reg  [7:0]                  dirD;
	reg  [2:0]                  dirE;
	reg  [31:0]                 rdData_d;

	wire globalPullupDisable = ctrl_q[`PDMUX_CTL_PUD];
	wire extMemEnable        = ctrl_q[`PDMUX_CTL_EXTMEM];
	wire timer2AsyncSelect   = ctrl_q[`PDMUX_CTL_T2ASYNC];
	wire serial0TxEnable     = ctrl_q[`PDMUX_CTL_TX0EN];
	wire serial0RxEnable     = ctrl_q[`PDMUX_CTL_RX0EN];
	wire serial0SyncMode     = ctrl_q[`PDMUX_CTL_S0SYNC];
	wire serial1SyncMode     = ctrl_q[`PDMUX_CTL_S1SYNC];
	wire irqZeroEnable       = ctrl_q[`PDMUX_CTL_IRQ0EN];
	wire irqOneEnable        = ctrl_q[`PDMUX_CTL_IRQ1EN];
	wire irqTwoEnable        = ctrl_q[`PDMUX_CTL_IRQ2EN];
	wire t1CmpAEnable        = ctrl_q[`PDMUX_CTL_T1AEN];
	wire t3CmpAEnable        = ctrl_q[`PDMUX_CTL_T3AEN];
	wire t1CmpBEnable        = ctrl_q[`PDMUX_CTL_T1BEN];

	// Clock outputs follow the direction bit, only in synchronous mode
	wire xck1OutEn = serial1SyncMode & dirD_q[2];
	wire xck0OutEn = serial0SyncMode & dirD_q[4];

	// Pads are asynchronous: two flops before anything reads them
	pdmux_sync #(
		.WIDTH (8)
	) uSyncD (
		.clock   (clock),
		.srst    (srst),
		.asyncIn (padDIn),
		.syncOut (syncD)
	);

	pdmux_sync #(
		.WIDTH (3)
	) uSyncE (
		.clock   (clock),
		.srst    (srst),
		.asyncIn (padEIn),
		.syncOut (syncE)
	);

	// Input levels gated by the enable actually applied at the pad
	always @* begin
		inD = syncD & padDInEn;
		inE = syncE & padEInEn;
	end

	// Port D override network
	always @* begin
		dirD = dirD_q;
		// Software defaults: pull-up only on inputs with data bit set
		puD_d  = dataD_q & ~dirD_q & {8{~globalPullupDisable}};
		outD_d = dataD_q;
		ieD_d  = 8'hff;
		// D7/D6 strobes; inputs also dropped while memory owns them
		dirD[7]   = pick(extMemEnable, 1'b1, dirD[7]);
		puD_d[7]  = pick(extMemEnable, 1'b0, puD_d[7]);
		outD_d[7] = pick(extMemEnable, memReadStrobe, outD_d[7]);
		ieD_d[7]  = pick(extMemEnable, 1'b0, ieD_d[7]);
		dirD[6]   = pick(extMemEnable, 1'b1, dirD[6]);
		puD_d[6]  = pick(extMemEnable, 1'b0, puD_d[6]);
		outD_d[6] = pick(extMemEnable, memWriteStrobe, outD_d[6]);
		ieD_d[6]  = pick(extMemEnable, 1'b0, ieD_d[6]);
		// D5: compare A unless the oscillator owns the pin
		outD_d[5] = pick(t1CmpAEnable, timer1CompareAOut, outD_d[5]);
		dirD[5]   = pick(timer2AsyncSelect, 1'b0, dirD[5]);
		puD_d[5]  = pick(timer2AsyncSelect, 1'b0, puD_d[5]);
		ieD_d[5]  = pick(timer2AsyncSelect, 1'b0, ieD_d[5]);
		// D4: serial0 clock wins over compare A
		outD_d[4] = pick(xck0OutEn | t3CmpAEnable,
			xck0OutEn ? serial0ExtClockOut : timer3CompareAOut,
			outD_d[4]);
		dirD[4]   = pick(timer2AsyncSelect, 1'b0, dirD[4]);
		puD_d[4]  = pick(timer2AsyncSelect, 1'b0, puD_d[4]);
		ieD_d[4]  = pick(timer2AsyncSelect, 1'b0, ieD_d[4]);
		// D3/D2: only input enable and value may be overridden
		ieD_d[3]  = pick(irqOneEnable, 1'b1, ieD_d[3]);
		ieD_d[2]  = pick(irqZeroEnable, 1'b1, ieD_d[2]);
		outD_d[2] = pick(xck1OutEn, serial1ExtClockOut,
			outD_d[2]);
		// D1 transmit, D0 receive
		dirD[1]   = pick(serial0TxEnable, 1'b1, dirD[1]);
		puD_d[1]  = pick(serial0TxEnable, 1'b0, puD_d[1]);
		outD_d[1] = pick(serial0TxEnable, serial0TxLine,
			outD_d[1]);
		dirD[0]   = pick(serial0RxEnable, 1'b0, dirD[0]);
		// Pull-up stays with software even while the receiver owns D0
		puD_d[0]  = pick(serial0RxEnable,
			dataD_q[0] & ~globalPullupDisable, puD_d[0]);
		oeND_d = ~dirD;
	end

	// Port E override network
	always @* begin
		dirE   = dirE_q;
		puE_d  = dataE_q & ~dirE_q & {3{~globalPullupDisable}};
		outE_d = dataE_q;
		ieE_d  = 3'h7;
		// E2 value only; direction must be set by software
		outE_d[2] = pick(t1CmpBEnable, timer1CompareBOut,
			outE_d[2]);
		dirE[1]   = pick(extMemEnable, 1'b1, dirE[1]);
		puE_d[1]  = pick(extMemEnable, 1'b0, puE_d[1]);
		outE_d[1] = pick(extMemEnable, memAddrLatch, outE_d[1]);
		ieE_d[0]  = pick(irqTwoEnable, 1'b1, ieE_d[0]);
		oeNE_d = ~dirE;
	end

	// Registered pad drive so every output comes from a flop
	always @(posedge clock) begin
		if (srst) begin
			padDOut    <= 8'h00;
			padDOeN    <= 8'hff;
			padDPullUp <= 8'h00;
			padDInEn   <= 8'hff;
			padEOut    <= 3'h0;
			padEOeN    <= 3'h7;
			padEPullUp <= 3'h0;
			padEInEn   <= 3'h7;
		end else begin
			padDOut    <= outD_d;
			padDOeN    <= oeND_d;
			padDPullUp <= puD_d;
			padDInEn   <= ieD_d;
			padEOut    <= outE_d;
			padEOeN    <= oeNE_d;
			padEPullUp <= puE_d;
			padEInEn   <= ieE_d;
		end
	end

	// Pin levels to the peripherals; interrupt masking is theirs
	always @(posedge clock) begin
		if (srst) begin
			extIrqZero        <= 1'b0;
			extIrqOne         <= 1'b0;
			extIrqTwo         <= 1'b0;
			captureInTimer1   <= 1'b0;
			captureInTimer3   <= 1'b0;
			serial0RxLine     <= 1'b0;
			serial0ExtClockIn <= 1'b0;
			serial1ExtClockIn <= 1'b0;
		end else begin
			extIrqOne         <= inD[3];
			captureInTimer3   <= inD[3];
			extIrqZero        <= inD[2];
			serial1ExtClockIn <= inD[2] & serial1SyncMode
				& ~dirD_q[2];
			serial0RxLine     <= inD[0];
			serial0ExtClockIn <= inD[4] & serial0SyncMode & ~dirD_q[4];
			captureInTimer1   <= inE[0];
			extIrqTwo         <= inE[0];
		end
	end

	// Read mux; unmapped words read as zero
	always @* begin
		rdData_d = 32'h00000000;
		if (hit(avs_address, `PDMUX_OFS_DDATA))
			rdData_d[7:0] = dataD_q;
		else if (hit(avs_address, `PDMUX_OFS_DDIR))
			rdData_d[7:0] = dirD_q;
		else if (hit(avs_address, `PDMUX_OFS_DPIN))
			rdData_d[7:0] = inD;
		else if (hit(avs_address, `PDMUX_OFS_EDATA))
			rdData_d[2:0] = dataE_q;
		else if (hit(avs_address, `PDMUX_OFS_EDIR))
			rdData_d[2:0] = dirE_q;
		else if (hit(avs_address, `PDMUX_OFS_EPIN))
			rdData_d[2:0] = inE;
		else if (hit(avs_address, `PDMUX_OFS_CTRL))
			rdData_d[`PDMUX_CTL_WIDTH-1:0] = ctrl_q;
	end

	// One wait state: waitrequest drops for one cycle per request.
	// Costs a cycle, but keeps waitrequest a plain flop.
	always @(posedge clock) begin
		if (srst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h00000000;
		end else begin
			if ((avs_read | avs_write) & avs_waitrequest) begin
				avs_waitrequest <= 1'b0;
				avs_readdata    <= rdData_d;
			end else begin
				avs_waitrequest <= 1'b1;
			end
		end
	end

	// Writes land at the edge where waitrequest is seen low
	always @(posedge clock) begin
		if (srst) begin
			dataD_q <= `PDMUX_RST_PORTD;
			dirD_q  <= `PDMUX_RST_PORTD;
			dataE_q <= `PDMUX_RST_PORTE;
			dirE_q  <= `PDMUX_RST_PORTE;
			ctrl_q  <= `PDMUX_RST_CTRL;
		end else if (avs_write & ~avs_waitrequest) begin
			if (hit(avs_address, `PDMUX_OFS_DDATA))
				dataD_q <= avs_writedata[7:0];
			if (hit(avs_address, `PDMUX_OFS_DDIR))
				dirD_q <= avs_writedata[7:0];
			if (hit(avs_address, `PDMUX_OFS_EDATA))
				dataE_q <= avs_writedata[2:0];
			if (hit(avs_address, `PDMUX_OFS_EDIR))
				dirE_q <= avs_writedata[2:0];
			if (hit(avs_address, `PDMUX_OFS_CTRL))
				ctrl_q <= avs_writedata[`PDMUX_CTL_WIDTH-1:0];
		end
	end

endmodule

// ---- test/pdmux_periph.sv ----
// Model of the peripherals that feed alternate pad values.
// Assumes one shared clock; hold freezes all lines.
module pdmux_periph (
	input  wire logic       clock,
	input  wire logic       hold,
	output logic      [8:0] lines
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [8:0] cnt_q = 9'h000;
	assign lines = cnt_q;
	// Odd step, so every line moves at its own rate
	always @(posedge clock) begin
		if (!hold)
			cnt_q <= cnt_q + 9'h0b7;
	end
endmodule

// ---- test/pdmux_top_checker.sv ----
// Port relations of the pad override block.
// Assumes a bind to pdmux_top; sees only its ports.
module pdmux_top_checker (
	input wire logic       clock,
	input wire logic       srst,
	input wire logic       avs_read,
	input wire logic       avs_write,
	input wire logic       avs_waitrequest,
	input wire logic [7:0] padDOut,
	input wire logic [7:0] padDOeN,
	input wire logic [7:0] padDPullUp,
	input wire logic [7:0] padDInEn,
	input wire logic [2:0] padEOut,
	input wire logic [2:0] padEOeN,
	input wire logic [2:0] padEPullUp,
	input wire logic       memReadStrobe,
	input wire logic       memWriteStrobe,
	input wire logic       memAddrLatch,
	input wire logic       extIrqOne,
	input wire logic       extIrqTwo,
	input wire logic       captureInTimer1,
	input wire logic       captureInTimer3,
	input wire logic       serial1ExtClockIn
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);
	// Bus answer: a single low cycle, then high again
	sequence reqSeen; (avs_read || avs_write) && avs_waitrequest; endsequence
	sequence ansPulse; !avs_waitrequest ##1 avs_waitrequest; endsequence
	bus_answer_a: assert property (reqSeen |=> ansPulse)
		else $error("bus answer not one low cycle");
	bus_idle_a: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
		else $error("answer without request");
	d3_shared_a: assert property (captureInTimer3 == extIrqOne)
		else $error("pin D3 paths differ");
	e0_shared_a: assert property (captureInTimer1 == extIrqTwo)
		else $error("pin E0 paths differ");
	pullup_input_a: assert property ((padDPullUp & ~padDOeN) == 8'h00
		&& (padEPullUp & ~padEOeN) == 3'h0) else $error("pull-up on output");
	// Input disable on D7 marks the memory takeover
	mem_strobes_a: assert property (!padDInEn[7] |-> padDOeN[7:6] == 2'h0
		&& padDPullUp[7:6] == 2'h0
		&& padDOut[7:6] == $past({memReadStrobe, memWriteStrobe}))
		else $error("strobes not on D7/D6");
	mem_latch_a: assert property (!padDInEn[7] |-> !padEOeN[1]
		&& !padEPullUp[1] && padEOut[1] == $past(memAddrLatch))
		else $error("latch strobe not on E1");
	osc_pins_a: assert property (!padDInEn[5] |-> padDOeN[5:4] == 2'h3
		&& padDPullUp[5:4] == 2'h0 && !padDInEn[4])
		else $error("oscillator pins not released");
	clk_input_a: assert property (serial1ExtClockIn |-> padDOeN[2])
		else $error("clock input while D2 drives");
endmodule
bind pdmux_top pdmux_top_checker chk (.clock, .srst, .avs_read, .avs_write,
	.avs_waitrequest, .padDOut, .padDOeN, .padDPullUp, .padDInEn, .padEOut,
	.padEOeN, .padEPullUp, .memReadStrobe, .memWriteStrobe, .memAddrLatch,
	.extIrqOne, .extIrqTwo, .captureInTimer1, .captureInTimer3,
	.serial1ExtClockIn);

// ---- test/pdmux_top_bench.sv ----
// Bench for the pad override block: bus tasks and pad checks.
// Assumes pdmux_top, the peripheral model and the checker.
module pdmux_top_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clock = 1'b0;
	logic        srst = 1'b1;
	logic        hold = 1'b0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic        avs_waitrequest;
	logic [4:0]  avs_address = 5'h00;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic [7:0]  padDIn = 8'h00;
	logic [2:0]  padEIn = 3'h0;
	logic [7:0]  padDOut, padDOeN, padDPullUp, padDInEn;
	logic [2:0]  padEOut, padEOeN, padEPullUp, padEInEn;
	logic [8:0]  pl;
	logic        extIrqZero, extIrqOne, extIrqTwo, captureInTimer1;
	logic        captureInTimer3, serial0RxLine, serial0ExtClockIn;
	logic        serial1ExtClockIn;
	int          err_total = 0;
	int          num_checks = 0;
	pdmux_periph periph (.clock, .hold, .lines(pl));
	pdmux_top DUT (.clock, .srst, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_readdata, .avs_waitrequest, .padDIn, .padDOut,
		.padDOeN, .padDPullUp, .padDInEn, .padEIn, .padEOut, .padEOeN,
		.padEPullUp, .padEInEn, .serial0TxLine(pl[0]),
		.serial0ExtClockOut(pl[1]), .serial1ExtClockOut(pl[2]),
		.memReadStrobe(pl[3]), .memWriteStrobe(pl[4]), .memAddrLatch(pl[5]),
		.timer1CompareAOut(pl[6]), .timer3CompareAOut(pl[7]),
		.timer1CompareBOut(pl[8]), .extIrqZero, .extIrqOne, .extIrqTwo,
		.captureInTimer1, .captureInTimer3, .serial0RxLine,
		.serial0ExtClockIn, .serial1ExtClockIn);
	initial begin
		forever #50 clock = ~clock;
	end
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// One transfer, held until waitrequest low; an idle edge follows
	task automatic acc(input logic w, input logic [4:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do begin
			@(posedge clock);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (n == 50) begin
			err_total++;
			final_report();
		end else begin
			@(posedge clock);
		end
	endtask
	task automatic rdChk(input logic [4:0] a, input logic [31:0] e);
		logic [31:0] q;
		acc(1'b0, a, 32'h0, q);
		num_checks++;
		if (q !== e) begin
			err_total++;
			$display("CHECK FAILED reg %h exp %h got %h", a, e, q);
		end
	endtask
	task automatic pinChk(input string s, input logic [7:0] e,
		input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s exp %h got %h", s, e, g);
		end
	endtask
	// Data, direction, control; then room for the pad sync latency
	task automatic cfg(input logic [12:0] c, input logic [7:0] dd,
		input logic [7:0] dr);
		logic [31:0] q;
		acc(1'b1, 5'h00, {24'h0, dd}, q);
		acc(1'b1, 5'h04, {24'h0, dr}, q);
		acc(1'b1, 5'h18, {19'h0, c}, q);
		repeat (4) @(posedge clock);
	endtask
	initial begin
		logic [31:0] q;
		repeat (5) @(posedge clock);
		srst <= 1'b0;
		hold <= 1'b1;
		@(posedge clock);
		pinChk("d oen", 8'hff, padDOeN);
		rdChk(5'h18, 32'h0);
		rdChk(5'h1c, 32'h0);
		cfg(13'h0000, 8'hff, 8'h02);
		pinChk("d pu", 8'hfd, padDPullUp);
		cfg(13'h0008, {6'h3f, ~pl[0], 1'b1}, 8'h00);
		pinChk("d oen", 8'hfd, padDOeN);
		pinChk("d pu", 8'hfd, padDPullUp);
		pinChk("d out", {6'h3f, pl[0], 1'b1}, padDOut);
		cfg(13'h0010, 8'h01, 8'h01);
		pinChk("d oen", 8'hff, padDOeN);
		pinChk("d pu", 8'h01, padDPullUp);
		cfg(13'h0011, 8'h01, 8'h01);
		pinChk("d pu", 8'h00, padDPullUp);
		padDIn <= 8'h09;
		repeat (4) @(posedge clock);
		pinChk("rx", 8'h01, serial0RxLine);
		pinChk("irq1", 8'h01, extIrqOne);
		pinChk("cap3", 8'h01, captureInTimer3);
		rdChk(5'h08, 32'h09);
		cfg(13'h01c0, {5'h0, ~pl[2], 2'h0}, 8'h0c);
		pinChk("d oen", 8'hf3, padDOeN);
		pinChk("d out", {5'h0, pl[2], 2'h0}, padDOut);
		padDIn <= 8'h04;
		cfg(13'h0040, 8'h00, 8'h00);
		pinChk("clk1", 8'h01, serial1ExtClockIn);
		pinChk("irq0", 8'h01, extIrqZero);
		cfg(13'h0000, 8'h00, 8'h00);
		pinChk("clk1", 8'h00, serial1ExtClockIn);
		// Compare A on D5/D4; serial0 clock output wins on D4
		cfg(13'h0c20, {2'h0, ~pl[6], ~pl[1], 4'h0}, 8'h30);
		pinChk("d out", {2'h0, pl[6], pl[1], 4'h0}, padDOut);
		padDIn <= 8'h10;
		cfg(13'h0c00, {2'h0, ~pl[6], ~pl[7], 4'h0}, 8'h30);
		pinChk("d out", {2'h0, pl[6], pl[7], 4'h0}, padDOut);
		pinChk("clk0", 8'h00, serial0ExtClockIn);
		// Clock input only reaches serial0 in synchronous mode
		cfg(13'h0020, 8'h00, 8'h00);
		pinChk("clk0", 8'h01, serial0ExtClockIn);
		cfg(13'h0004, 8'hff, 8'hff);
		pinChk("d oen", 8'h30, padDOeN);
		pinChk("d inen", 8'hcf, padDInEn);
		// Sources run so the checker sees strobes move
		hold <= 1'b0;
		cfg(13'h0002, 8'hff, 8'h00);
		hold <= 1'b1;
		repeat (2) @(posedge clock);
		pinChk("d out", {pl[3], pl[4], 6'h3f}, padDOut);
		pinChk("d inen", 8'h3f, padDInEn);
		pinChk("e oen", 8'h05, padEOeN);
		pinChk("e out", {5'h0, pl[5], 1'b0}, padEOut);
		acc(1'b1, 5'h10, 32'h4, q);
		acc(1'b1, 5'h0c, {29'h0, ~pl[8], 2'h3}, q);
		padEIn <= 3'h1;
		cfg(13'h1000, 8'h00, 8'h00);
		pinChk("e out", {5'h0, pl[8], 2'h3}, padEOut);
		pinChk("e pu", 8'h03, padEPullUp);
		pinChk("e inen", 8'h07, padEInEn);
		pinChk("irq2", 8'h01, extIrqTwo);
		pinChk("cap1", 8'h01, captureInTimer1);
		rdChk(5'h14, 32'h1);
		rdChk(5'h18, 32'h1000);
		// Mid-run reset: registers and pads return to idle
		srst <= 1'b1;
		repeat (3) @(posedge clock);
		srst <= 1'b0;
		@(posedge clock);
		pinChk("e oen", 8'h07, padEOeN);
		pinChk("e out", 8'h00, padEOut);
		rdChk(5'h18, 32'h0);
		rdChk(5'h0c, 32'h0);
		final_report();
	end
endmodule
